/* ssfr_port.sv */
// Summary of operation
// - Each frame carries a data word of 4 to 16 bits as programmed.
// - Words are shifted most significant bit first in every format.
// - The serial clock rests low between transfers, except in select format with cpol set, where it rests high.
// - Serial clock edges occur only while a frame is in progress, apart from one step to a new idle level just before a frame that changes it.
// - The frame signal marks where each frame begins, and in select and command formats where it ends.
// - A separate output enables an external line driver.
// - Pulse format: frame high one clock period from a rising edge before the word.
// - Pulse format: data changes on rising edges, captured on falling edges.
// - Pulse and select formats move one word each way per frame.
// - Command format: frame is active low and held low for the frame.
// - Command format: data changes on falling edges, sampled on rising edges.
// - Command format: each frame opens with an 8-bit control message.
// - Command format: receive line ignored while the control message goes out.
// - Command format response is 4 to 16 bits; frame spans 13 to 25 periods.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ssfr_port
  import ssfr_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_rstn,
  input  wire logic        i_link_clock,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic        i_serial_rx_in,
  output logic             o_serial_bit_clock_out,
  output logic             o_frame_sync_out,
  output logic             o_serial_tx_out,
  output logic             o_line_driver_enable
);

  // ==========================================================
  // State of both domains
  typedef struct packed {
    ssfr_cfg_type cfg;
    logic [15:0]  tx;
    ssfr_cfg_type cfg_snap;
    logic [15:0]  tx_snap;
    logic [15:0]  rx;
    logic         busy;
    logic         rx_full;
    logic         start_tgl;
    logic         done_s1;
    logic         done_s2;
    logic         done_seen;
    logic [31:0]  rdata;
  } ssfr_sys_type;

  typedef struct packed {
    ssfr_lstate_type state;
    ssfr_cfg_type    cfg;
    logic [23:0]     sh;
    logic [15:0]     rx_sh;
    logic [15:0]     rx_word;
    logic [4:0]      cnt;
    logic            half;
    logic            sub;
    logic [1:0]      cap;
    logic [1:0]      flush;
    logic            start_s1;
    logic            start_s2;
    logic            start_seen;
    logic            rx_s1;
    logic            rx_s2;
    logic            done_tgl;
    logic            sclk;
    logic            frame;
    logic            txd;
    logic            drv;
  } ssfr_link_type;

  localparam ssfr_sys_type SYS_RST = '{
    cfg: SSFR_CFG_RST, cfg_snap: SSFR_CFG_RST, default: '0};
  localparam ssfr_link_type LINK_RST = '{
    state: SSFR_L_IDLE, cfg: SSFR_CFG_RST, frame: 1'b1, default: '0};

  ssfr_sys_type  sq, sn;
  ssfr_link_type lq, ln;

  // ==========================================================
  // Format helpers
  function automatic logic f_pulse(input ssfr_cfg_type c);
    return c.fmt == SSFR_FMT_PULSE;
  endfunction : f_pulse

  function automatic logic f_cmd(input ssfr_cfg_type c);
    return c.fmt == SSFR_FMT_CMD;
  endfunction : f_cmd

  // Clock inversion applies only to the select format
  function automatic logic f_inv(input ssfr_cfg_type c);
    return !f_pulse(c) && !f_cmd(c) && c.cpol;
  endfunction : f_inv

  // Raw clock level in the first half of each bit period
  function automatic logic f_hi0(input ssfr_cfg_type c);
    return f_pulse(c) || (!f_cmd(c) && c.cpha);
  endfunction : f_hi0

  function automatic logic [4:0] f_bits(input ssfr_cfg_type c);
    logic [3:0] d;
    d = (c.dsize < SSFR_DSIZE_MIN) ? SSFR_DSIZE_MIN : c.dsize;
    return {1'b0, d} + 5'h01;
  endfunction : f_bits

  function automatic logic [4:0] f_total(input ssfr_cfg_type c);
    logic [4:0] t;
    t = f_bits(c);
    if (f_pulse(c)) t = t + 5'h01;
    if (f_cmd(c)) t = t + SSFR_RESP_START;
    return t;
  endfunction : f_total

  function automatic logic f_txwin(input ssfr_cfg_type c, input logic [4:0] p);
    if (f_cmd(c)) return p < SSFR_CMD_BITS;
    return p >= {4'h0, f_pulse(c)};
  endfunction : f_txwin

  function automatic logic f_rxwin(input ssfr_cfg_type c, input logic [4:0] p);
    if (f_cmd(c)) return p >= SSFR_RESP_START;
    return p >= {4'h0, f_pulse(c)};
  endfunction : f_rxwin

  // Left-align the outgoing message so bit 23 leaves first
  function automatic logic [23:0] f_load(input ssfr_cfg_type c, input logic [15:0] w);
    logic [15:0] al;
    al = w << (SSFR_WORD_MAX - f_bits(c));
    if (f_cmd(c)) return {c.cmd, 16'h0000};
    return {al, 8'h00};
  endfunction : f_load

  // ==========================================================
  // System domain: register slave
  logic done_ev;

  always_comb begin
    sn         = sq;
    sn.done_s1 = lq.done_tgl;
    sn.done_s2 = sq.done_s1;
    sn.rdata   = 32'h0000_0000;
    done_ev    = sq.done_s2 != sq.done_seen;
    if (done_ev) begin
      sn.done_seen = sq.done_s2;
      sn.busy      = 1'b0;
      sn.rx        = lq.rx_word;
    end
    if (i_wr) begin
      case (i_addr)
        SSFR_CTRL_ADDR: sn.cfg = ssfr_cfg_type'(i_wdata[15:0]);
        SSFR_TXDATA_ADDR: begin
          sn.tx = i_wdata[15:0];
          if (!sq.busy) begin
            sn.cfg_snap  = sq.cfg;
            sn.tx_snap   = i_wdata[15:0];
            sn.busy      = 1'b1;
            sn.start_tgl = ~sq.start_tgl;
          end
        end
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        SSFR_CTRL_ADDR:   sn.rdata = {16'h0000, sq.cfg};
        SSFR_TXDATA_ADDR: sn.rdata = {16'h0000, sq.tx};
        SSFR_RXDATA_ADDR: begin
          sn.rdata   = {16'h0000, sq.rx};
          sn.rx_full = 1'b0;
        end
        SSFR_STATUS_ADDR: begin
          sn.rdata[SSFR_BUSY_BIT]   = sq.busy;
          sn.rdata[SSFR_RXFULL_BIT] = sq.rx_full;
        end
        default: sn.rdata = 32'h0000_0000;
      endcase
    end
    // New word beats a clearing read in the same cycle
    if (done_ev) sn.rx_full = 1'b1;
  end

  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) sq <= SYS_RST;
    else sq <= sn;
  end

  // ==========================================================
  // Link domain: frame engine
  ssfr_cfg_type c;
  logic         pstart;
  logic [4:0]   pcnt;
  logic [23:0]  shl;

  always_comb begin
    ln          = lq;
    c           = lq.cfg;
    pstart      = 1'b0;
    pcnt        = lq.cnt;
    shl         = lq.sh;
    ln.start_s1 = sq.start_tgl;
    ln.start_s2 = lq.start_s1;
    ln.rx_s1    = i_serial_rx_in;
    ln.rx_s2    = lq.rx_s1;
    // Capture lags the sampling edge by the two synchroniser stages
    ln.cap      = {lq.cap[0], 1'b0};
    if (lq.cap[1]) ln.rx_sh = {lq.rx_sh[14:0], lq.rx_s2};
    case (lq.state)
      SSFR_L_IDLE: begin
        ln.sclk  = f_inv(c);
        ln.frame = !f_pulse(c);
        ln.txd   = 1'b0;
        ln.drv   = 1'b0;
        if (lq.start_s2 != lq.start_seen) begin
          ln.cfg = sq.cfg_snap;
        end
        // A change of idle levels (format or cpol) settles the new levels for one cycle first,
        // so the frame opens with a real frame edge and no stray clock edge
        if (lq.start_s2 != lq.start_seen
            && (lq.frame == f_pulse(sq.cfg_snap) || lq.sclk != f_inv(sq.cfg_snap))) begin
          ln.sclk  = f_inv(sq.cfg_snap);
          ln.frame = !f_pulse(sq.cfg_snap);
        end else if (lq.start_s2 != lq.start_seen) begin
          c             = sq.cfg_snap;
          ln.start_seen = lq.start_s2;
          ln.state      = SSFR_L_RUN;
          ln.cnt        = 5'h00;
          ln.half       = 1'b0;
          ln.sub        = 1'b0;
          ln.rx_sh      = 16'h0000;
          ln.drv        = 1'b1;
          shl           = f_load(sq.cfg_snap, sq.tx_snap);
          pstart        = 1'b1;
          pcnt          = 5'h00;
        end
      end
      SSFR_L_RUN: begin
        ln.sub = ~lq.sub;
        if (lq.sub == SSFR_HALF_LAST) begin
          if (!lq.half) begin
            ln.half   = 1'b1;
            ln.sclk   = !f_hi0(c) ^ f_inv(c);
            ln.cap[0] = f_rxwin(c, lq.cnt);
          end else if (lq.cnt == f_total(c) - 5'h01) begin
            ln.state = SSFR_L_FLUSH;
            ln.flush = 2'h0;
            ln.sclk  = f_inv(c);
            ln.frame = !f_pulse(c);
            ln.txd   = 1'b0;
            ln.drv   = 1'b0;
          end else begin
            ln.half = 1'b0;
            pstart  = 1'b1;
            pcnt    = lq.cnt + 5'h01;
            ln.cnt  = pcnt;
          end
        end
      end
      SSFR_L_FLUSH: begin
        ln.flush = lq.flush + 2'h1;
        if (lq.flush == SSFR_FLUSH_LAST) begin
          ln.rx_word  = lq.rx_sh;
          ln.done_tgl = ~lq.done_tgl;
          ln.state    = SSFR_L_IDLE;
        end
      end
      default: ln.state = SSFR_L_IDLE;
    endcase
    // Opening edge of each bit period
    if (pstart) begin
      ln.sclk  = f_hi0(c) ^ f_inv(c);
      ln.frame = f_pulse(c) && (pcnt == 5'h00);
      if (f_txwin(c, pcnt)) begin
        ln.txd = shl[23];
        ln.sh  = {shl[22:0], 1'b0};
      end else begin
        ln.txd = 1'b0;
        ln.sh  = shl;
      end
    end
  end

  always_ff @(posedge i_link_clock or negedge i_rstn) begin
    if (!i_rstn) lq <= LINK_RST;
    else lq <= ln;
  end

  assign o_rdata                = sq.rdata;
  assign o_serial_bit_clock_out = lq.sclk;
  assign o_frame_sync_out       = lq.frame;
  assign o_serial_tx_out        = lq.txd;
  assign o_line_driver_enable   = lq.drv;

  // ==========================================================
  // Checks on the link side
  default clocking cb @(posedge i_link_clock);
  endclocking
  default disable iff (!i_rstn);

  logic       a_raw;
  logic       a_raw_q;
  logic [4:0] a_edges;
  logic       a_run;
  logic       a_pul;
  logic       a_cmd;

  assign a_raw = lq.sclk ^ f_inv(lq.cfg);
  assign a_run = lq.state == SSFR_L_RUN;
  assign a_pul = f_pulse(lq.cfg);
  assign a_cmd = f_cmd(lq.cfg);

  always_ff @(posedge i_link_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      a_raw_q <= 1'b0;
      a_edges <= 5'h00;
    end else begin
      a_raw_q <= a_raw;
      if (lq.state == SSFR_L_IDLE) a_edges <= 5'h00;
      else if (a_raw && !a_raw_q) a_edges <= a_edges + 5'h01;
    end
  end

  property p_idle_clk;
    lq.state == SSFR_L_IDLE && !f_inv(lq.cfg) |-> !lq.sclk;
  endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock not low at idle");

  property p_quiet_idle;
    lq.state == SSFR_L_IDLE && $past(lq.state) == SSFR_L_IDLE |-> $stable(a_raw);
  endproperty
  a_quiet_idle: assert property (p_quiet_idle) else $error("clock edge between frames");

  property p_frame_len;
    $rose(lq.state == SSFR_L_FLUSH) |-> a_edges == f_total(lq.cfg);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("wrong clock count in frame");

  property p_pulse_frame;
    a_pul && $rose(lq.frame) |-> (lq.sclk && lq.frame) ##1 lq.frame[*3] ##1 !lq.frame;
  endproperty
  a_pulse_frame: assert property (p_pulse_frame) else $error("frame pulse not one period");

  property p_pulse_tx;
    a_pul && a_run && $changed(lq.txd) |-> $rose(lq.sclk);
  endproperty
  a_pulse_tx: assert property (p_pulse_tx) else $error("pulse data off rising edge");

  property p_cmd_frame;
    a_cmd && a_run |-> !lq.frame;
  endproperty
  a_cmd_frame: assert property (p_cmd_frame) else $error("command frame not low");

  property p_cmd_tx;
    a_cmd && a_run && $past(a_run) && $changed(lq.txd) |-> $fell(lq.sclk);
  endproperty
  a_cmd_tx: assert property (p_cmd_tx) else $error("command data off falling edge");

  property p_cmd_msb;
    a_cmd && $fell(lq.frame) |-> lq.txd == lq.cfg.cmd[7];
  endproperty
  a_cmd_msb: assert property (p_cmd_msb) else $error("control message not msb first");

  property p_cmd_no_rx;
    a_cmd && a_run && lq.cnt < SSFR_RESP_START |-> !lq.cap[0];
  endproperty
  a_cmd_no_rx: assert property (p_cmd_no_rx) else $error("capture during control");

  property p_drv_en;
    a_run |-> lq.drv ##0 (lq.frame != f_pulse(lq.cfg) || lq.cnt == 5'h00 || !a_pul);
  endproperty
  a_drv_en: assert property (p_drv_en) else $error("driver enable off in frame");

  c_pulse_done: cover property (a_pul && $rose(lq.state == SSFR_L_FLUSH));
  c_cmd_done:   cover property (a_cmd && $rose(lq.state == SSFR_L_FLUSH));
  c_sel_inv:    cover property (f_inv(lq.cfg) && lq.cfg.cpha && $rose(lq.state == SSFR_L_FLUSH));
endmodule : ssfr_port

/* ssfr_pkg.sv */
package ssfr_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  SSFR_CTRL_ADDR   = 8'h00;
  localparam logic [7:0]  SSFR_TXDATA_ADDR = 8'h04;
  localparam logic [7:0]  SSFR_RXDATA_ADDR = 8'h08;
  localparam logic [7:0]  SSFR_STATUS_ADDR = 8'h0c;
  localparam int          SSFR_BUSY_BIT    = 0;
  localparam int          SSFR_RXFULL_BIT  = 1;
  // ==========================================================
  // Frame geometry
  localparam logic [4:0]  SSFR_WORD_MAX    = 5'h10;
  localparam logic [3:0]  SSFR_DSIZE_MIN   = 4'h3;
  localparam logic [4:0]  SSFR_CMD_BITS    = 5'h08;
  localparam logic [4:0]  SSFR_RESP_START  = 5'h09;
  // ==========================================================
  // Timing in link clock cycles
  localparam logic        SSFR_HALF_LAST   = 1'b1;
  localparam logic [1:0]  SSFR_FLUSH_LAST  = 2'h1;
  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SSFR_FMT_SELECT = 2'b00,
    SSFR_FMT_PULSE  = 2'b01,
    SSFR_FMT_CMD    = 2'b10
  } ssfr_fmt_type;

  typedef enum logic [1:0] {
    SSFR_L_IDLE  = 2'b00,
    SSFR_L_RUN   = 2'b01,
    SSFR_L_FLUSH = 2'b10
  } ssfr_lstate_type;

  typedef struct packed {
    logic [7:0]   cmd;
    logic [3:0]   dsize;
    logic         cpha;
    logic         cpol;
    ssfr_fmt_type fmt;
  } ssfr_cfg_type;

  localparam ssfr_cfg_type SSFR_CFG_RST =
    '{cmd: 8'h00, dsize: 4'h7, cpha: 1'b0, cpol: 1'b0, fmt: SSFR_FMT_SELECT};
endpackage : ssfr_pkg

/* ssfr_slave.sv */
`timescale 1ns/100ps
// ==========================================================
// Far-side serial slave, behavioural
module ssfr_slave (
  input  wire logic        i_sclk,
  input  wire logic        i_frame,
  input  wire logic        i_tx,
  input  wire logic [1:0]  i_fmt,
  input  wire logic        i_cpol,
  input  wire logic        i_cpha,
  input  wire logic [15:0] i_reply,
  input  wire logic [4:0]  i_bits,
  output logic             o_rx,
  output logic      [15:0] o_got,
  output logic      [4:0]  o_ncap
);
  logic [15:0] sh;
  int          nout;
  int          nfall;
  logic        act;
  logic        cap_rise;
  assign cap_rise = (i_fmt == 2'h2) || (i_fmt == 2'h0 && i_cpol == i_cpha);
  initial begin
    o_rx   = 1'b0;
    act    = 1'b0;
    o_got  = 16'h0;
    o_ncap = 5'h0;
  end
  // Unused bit slots toggle so a stale level never passes
  task automatic send;
    if (nout < i_bits) begin
      o_rx = sh[15];
      sh   = sh << 1;
      nout++;
    end else begin
      o_rx = ~o_rx;
    end
  endtask : send
  always @(i_frame) begin
    #1;
    if ((i_fmt == 2'h1) == i_frame) begin
      act    = 1'b1;
      sh     = i_reply << (16 - i_bits);
      nout   = 0;
      nfall  = 0;
      o_got  = 16'h0;
      o_ncap = 5'h0;
      if (i_fmt == 2'h0 && !i_cpha) send();
    end else if (i_fmt != 2'h1) begin
      act  = 1'b0;
      o_rx = ~o_rx;
    end
  end
  // Settles after the frame block so a frame edge on the same step is seen first
  always @(i_sclk) begin
    #2;
    if (act && (i_fmt != 2'h1 || !i_frame)) begin
      if (i_sclk == cap_rise) begin
        if (o_ncap < ((i_fmt == 2'h2) ? 5'h08 : i_bits)) begin
          o_got  = {o_got[14:0], i_tx};
          o_ncap = o_ncap + 5'h1;
        end
      end else if (i_fmt == 2'h2) begin
        nfall++;
        if (nfall >= 9) send();
        else o_rx = ~o_rx;
      end else begin
        send();
      end
    end
  end
endmodule : ssfr_slave

/* ssfr_tb.sv */
`timescale 1ns/100ps
module tb import ssfr_pkg::*;;
  logic        i_clock;
  logic        i_rstn;
  logic        i_link_clock;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic        rx;
  logic        sclk;
  logic        frame;
  logic        tx;
  logic        line_en;
  logic [1:0]  s_fmt;
  logic        s_cpol;
  logic        s_cpha;
  logic [15:0] s_rep;
  logic [4:0]  s_bits;
  logic [15:0] got;
  logic [4:0]  ncap;
  int          fail_count = 0;
  int          num_checks = 0;
  int          rises = 0;
  int          frames = 0;
  int          hi_ns = 0;
  int          lo_ns = 0;
  realtime     t_edge = 0;
  ssfr_port dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_link_clock(i_link_clock),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_serial_rx_in(rx), .o_serial_bit_clock_out(sclk), .o_frame_sync_out(frame),
    .o_serial_tx_out(tx), .o_line_driver_enable(line_en));
  ssfr_slave peer (.i_sclk(sclk), .i_frame(frame), .i_tx(tx), .i_fmt(s_fmt), .i_cpol(s_cpol),
    .i_cpha(s_cpha), .i_reply(s_rep), .i_bits(s_bits), .o_rx(rx), .o_got(got), .o_ncap(ncap));
  // ==========================================================
  // Clocks and monitors
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    i_link_clock = 1'b0;
    #7;
    forever #40 i_link_clock = ~i_link_clock;
  end
  always @(posedge sclk) rises++;
  always @(posedge line_en) frames++;
  always @(frame) begin
    if (frame) lo_ns = int'($realtime - t_edge);
    else hi_ns = int'($realtime - t_edge);
    t_edge = $realtime;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clock);
    i_wr    <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clock);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask : rd
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  // One frame: configure, send, write again while busy without starting a second frame, check both words
  task automatic run(input logic [1:0] f, input logic pl, input logic ph, input int n,
                     input logic [15:0] w, input logic [15:0] rp, input logic [7:0] cm);
    logic [31:0] st;
    logic [15:0] m;
    int          r0;
    int          f0;
    int          k;
    m      = 16'hffff >> (16 - n);
    s_fmt  = f;
    s_cpol = pl;
    s_cpha = ph;
    s_rep  = rp;
    s_bits = 5'(n);
    wr(SSFR_CTRL_ADDR, {16'h0, cm, 4'(n - 1), ph, pl, f});
    repeat (40) @(posedge i_clock);
    r0 = rises;
    f0 = frames;
    wr(SSFR_TXDATA_ADDR, {16'h0, w});
    rd(SSFR_STATUS_ADDR, st);
    chk(st & 32'h1, 32'h1);
    wr(SSFR_TXDATA_ADDR, {16'h0, ~w});
    k = 0;
    while (st[SSFR_BUSY_BIT] === 1'b1 && k < 5000) begin
      rd(SSFR_STATUS_ADDR, st);
      k++;
    end
    chk(st, 32'h2);
    rd(SSFR_TXDATA_ADDR, st);
    chk(st, {16'h0, ~w});
    chk(32'(frames - f0), 32'h1);
    if (!pl) chk(32'(rises - r0), (f == 2'h1) ? n + 1 : (f == 2'h2) ? n + 9 : n);
    chk({16'h0, got}, (f == 2'h2) ? {24'h0, cm} : {16'h0, w & m});
    chk({27'h0, ncap}, (f == 2'h2) ? 32'h8 : 32'(n));
    rd(SSFR_RXDATA_ADDR, st);
    chk(st, {16'h0, rp & m});
    rd(SSFR_STATUS_ADDR, st);
    chk(st, 32'h0);
    r0 = rises;
    repeat (50) @(posedge i_clock);
    chk(32'(rises - r0), 32'h0);
    chk({31'h0, sclk}, {31'h0, pl && f == 2'h0});
    chk({31'h0, line_en}, 32'h0);
    if (f == 2'h1) chk(32'(hi_ns), 32'd320);
    if (f == 2'h2) chk(32'(lo_ns >= (9 + n) * 320 && lo_ns <= (10 + n) * 320), 32'h1);
    $display("Test format %0d size %0d done", f, n);
  endtask : run
  // ==========================================================
  // Sequence
  initial begin
    logic [31:0] st;
    i_rstn  = 1'b0;
    i_addr  = 8'h00;
    i_wdata = 32'h0;
    i_wr    = 1'b0;
    i_rd    = 1'b0;
    s_fmt   = 2'h0;
    s_cpol  = 1'b0;
    s_cpha  = 1'b0;
    s_rep   = 16'h0;
    s_bits  = 5'h4;
    repeat (6) @(posedge i_clock);
    i_rstn <= 1'b1;
    chk({29'h0, sclk, frame, line_en}, 32'h2);
    rd(SSFR_CTRL_ADDR, st);
    chk(st, 32'h70);
    wr(8'h10, 32'hffff);
    rd(8'h10, st);
    chk(st, 32'h0);
    rd(SSFR_CTRL_ADDR, st);
    chk(st, 32'h70);
    $display("Test reset done");
    run(2'h1, 1'b0, 1'b0, 4, 16'h0009, 16'h0006, 8'h00);
    run(2'h1, 1'b0, 1'b0, 16, 16'ha5c3, 16'h3c5a, 8'h00);
    run(2'h0, 1'b0, 1'b0, 8, 16'h0081, 16'h007e, 8'h00);
    run(2'h0, 1'b0, 1'b1, 12, 16'h0b2d, 16'h04d2, 8'h00);
    run(2'h0, 1'b1, 1'b0, 5, 16'h0015, 16'h000a, 8'h00);
    run(2'h0, 1'b1, 1'b1, 16, 16'h8001, 16'h7ffe, 8'h00);
    run(2'h2, 1'b0, 1'b0, 4, 16'h000c, 16'h0005, 8'hb4);
    run(2'h2, 1'b0, 1'b0, 16, 16'h1234, 16'hc3a5, 8'h2d);
    close_out();
  end
  initial begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule : tb
